/* File: src/scrmr_pkg.sv */
package scrmr_pkg;

  // Scrambler setting selected by the control processor, per direction.
  typedef enum logic [2:0] {
    SEL_AUTO        = 3'h0,
    SEL_FIRST_STD   = 3'h1,
    SEL_SECOND_STD  = 3'h2,
    SEL_V35         = 3'h3,
    SEL_SAT         = 3'h4,
    SEL_ALT_V35     = 3'h5,
    SEL_ALT_SAT     = 3'h6,
    SEL_PC_SYNC     = 3'h7
  } scrmr_sel_e;

  // Scrambler actually applied by the data path.
  typedef enum logic [2:0] {
    USE_SAT_SELFSYNC = 3'h0,
    USE_V35_SELFSYNC = 3'h1,
    USE_FRAMING_SYNC = 3'h2,
    USE_RS_SYNC      = 3'h3,
    USE_PC_SYNC      = 3'h4
  } scrmr_use_e;

  // APB register map.
  localparam logic [7:0]  ADDR_TX_CFG  = 8'h00;
  localparam logic [7:0]  ADDR_RX_CFG  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS  = 8'h08;

  // Configuration field layout, identical for both directions.
  localparam int          CFG_SEL_LSB  = 0;
  localparam int          CFG_PC_BIT   = 4;
  localparam int          CFG_FM_BIT   = 5;
  localparam int          CFG_RS_BIT   = 6;
  localparam int          CFG_FM_INST  = 8;
  localparam int          CFG_PC_INST  = 9;
  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;

  // Status field layout, one byte per direction.
  localparam int          STAT_TX_LSB  = 0;
  localparam int          STAT_RX_LSB  = 8;
  localparam int          STAT_INV_BIT = 4;

endpackage : scrmr_pkg

/* File: src/scrmr_dir_if.sv */
// Settings and result of one direction between the register file and a resolver.
interface scrmr_dir_if;
  import scrmr_pkg::*;

  scrmr_sel_e sel;
  logic       pc_en;
  logic       pc_inst;
  logic       fm_en;
  logic       fm_inst;
  logic       rs_en;
  scrmr_use_e use_sel;
  logic       invert;

  modport cfg (output sel, output pc_en, output pc_inst, output fm_en, output fm_inst, output rs_en,
               input use_sel, input invert);
  modport res (input sel, input pc_en, input pc_inst, input fm_en, input fm_inst, input rs_en,
               output use_sel, output invert);
endinterface : scrmr_dir_if

/* File: src/scrmr_dir_resolver.sv */
module scrmr_dir_resolver
  import scrmr_pkg::*;
(
  // Clock and reset.
  input  wire logic MCLK,
  input  wire logic RST,
  // Direction settings and result.
  scrmr_dir_if.res  dir
);

  scrmr_use_e use_ff;
  scrmr_use_e nxt_use;
  logic       inv_ff;
  logic       nxt_inv;
  logic       pc_on;
  logic       fm_on;

  // Standard-mode resolution; the second mode differs only when RS stands alone.
  function automatic scrmr_use_e std_pick(input logic second, input logic fm, input logic rs);
    scrmr_use_e r;
    r = USE_SAT_SELFSYNC;
    if (fm) begin
      r = USE_FRAMING_SYNC;
    end else if (rs && !second) begin
      r = USE_RS_SYNC;
    end
    return r;
  endfunction

  always_comb begin
    pc_on   = dir.pc_en && dir.pc_inst;
    fm_on   = dir.fm_en && dir.fm_inst;
    nxt_inv = 1'b0;
    case (dir.sel)
      SEL_AUTO: begin
        if (!pc_on) begin
          nxt_use = std_pick(1'b0, fm_on, dir.rs_en);
        end else if (!fm_on) begin
          nxt_use = USE_PC_SYNC;
        end else begin
          nxt_use = std_pick(1'b0, fm_on, dir.rs_en);
        end
      end
      SEL_FIRST_STD:  nxt_use = std_pick(1'b0, fm_on, dir.rs_en);
      SEL_SECOND_STD: nxt_use = std_pick(1'b1, fm_on, dir.rs_en);
      SEL_V35:        nxt_use = USE_V35_SELFSYNC;
      SEL_SAT:        nxt_use = USE_SAT_SELFSYNC;
      SEL_ALT_V35: begin
        nxt_use = USE_V35_SELFSYNC;
        nxt_inv = 1'b1;
      end
      SEL_ALT_SAT: begin
        nxt_use = USE_SAT_SELFSYNC;
        nxt_inv = 1'b1;
      end
      SEL_PC_SYNC:    nxt_use = USE_PC_SYNC;
      default:        nxt_use = USE_SAT_SELFSYNC;
    endcase
  end

  // One register stage: any change shows on the following edge.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      use_ff <= USE_SAT_SELFSYNC;
      inv_ff <= 1'b0;
    end else begin
      use_ff <= nxt_use;
      inv_ff <= nxt_inv;
    end
  end

  assign dir.use_sel = use_ff;
  assign dir.invert  = inv_ff;

endmodule : scrmr_dir_resolver

/* File: src/scrmr_top.sv */
// What this block does
// - In automatic mode with the product-code FEC absent or off, the scrambler resolves to a standard mode.
// - In automatic mode with the product-code FEC on and the framing multiplexer off, the product-code sync scrambler is used.
// - In automatic mode with both product-code FEC and framing multiplexer on, the first standard mode is used.
// - Transmit and receive settings are held separately and resolved independently.
// - First standard mode with neither multiplexer nor RS uses the satellite self-synchronizing scrambler.
// - First standard mode with only the multiplexer uses the multiplexer synchronous scrambler.
// - First standard mode with only RS uses the RS synchronous scrambler.
// - First standard mode with multiplexer and RS uses the multiplexer synchronous scrambler.
// - Second standard mode matches the first except that RS alone uses the satellite self-synchronizing scrambler.
// - Fixed V.35 and fixed satellite modes always use their own self-synchronizing scrambler.
// - Alternate V.35 and alternate satellite modes use that scrambler and also invert the data.
// - Multiplexer and RS enables are independent and exist separately per direction.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
module scrmr_top
  import scrmr_pkg::*;
(
  // Clock and reset.
  input  wire logic        MCLK,
  input  wire logic        RST,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Resolved scrambler per direction.
  output scrmr_use_e       TX_SCRAMBLER,
  output logic             TX_INVERT,
  output scrmr_use_e       RX_DESCRAMBLER,
  output logic             RX_INVERT
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] tx_cfg_ff;
  logic [31:0] nxt_tx_cfg;
  logic [31:0] rx_cfg_ff;
  logic [31:0] nxt_rx_cfg;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        setup;
  logic        mapped;

  scrmr_dir_if tx_if ();
  scrmr_dir_if rx_if ();

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == ADDR_TX_CFG) || (a == ADDR_RX_CFG) || (a == ADDR_STATUS);
  endfunction

  // Only the defined config bits are kept so reads show what steers the resolver.
  function automatic logic [31:0] cfg_mask(input logic [31:0] d);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[CFG_SEL_LSB +: 3] = d[CFG_SEL_LSB +: 3];
    m[CFG_PC_BIT]  = d[CFG_PC_BIT];
    m[CFG_FM_BIT]  = d[CFG_FM_BIT];
    m[CFG_RS_BIT]  = d[CFG_RS_BIT];
    m[CFG_FM_INST] = d[CFG_FM_INST];
    m[CFG_PC_INST] = d[CFG_PC_INST];
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // The slave answers in the first access cycle; pready drops again after it.
  always_comb begin
    setup       = PSEL && !PENABLE;
    mapped      = is_mapped(PADDR);
    nxt_tx_cfg  = tx_cfg_ff;
    nxt_rx_cfg  = rx_cfg_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    // Writes commit only at the access edge, so a setup that is abandoned changes nothing.
    if (PSEL && PENABLE && pready_ff && PWRITE) begin
      if (PADDR == ADDR_TX_CFG) begin
        nxt_tx_cfg = cfg_mask(PWDATA);
      end
      if (PADDR == ADDR_RX_CFG) begin
        nxt_rx_cfg = cfg_mask(PWDATA);
      end
    end
    if (setup) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = !mapped;
      nxt_prdata  = 32'h0000_0000;
      if (!PWRITE) begin
        case (PADDR)
          ADDR_TX_CFG: nxt_prdata = tx_cfg_ff;
          ADDR_RX_CFG: nxt_prdata = rx_cfg_ff;
          ADDR_STATUS: begin
            nxt_prdata[STAT_TX_LSB +: 3]            = TX_SCRAMBLER;
            nxt_prdata[STAT_TX_LSB + STAT_INV_BIT]  = TX_INVERT;
            nxt_prdata[STAT_RX_LSB +: 3]            = RX_DESCRAMBLER;
            nxt_prdata[STAT_RX_LSB + STAT_INV_BIT]  = RX_INVERT;
          end
          default:     nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      tx_cfg_ff      <= CFG_RESET;
      rx_cfg_ff      <= CFG_RESET;
      prdata_ff      <= 32'h0000_0000;
      pready_ff      <= 1'b0;
      pslverr_ff     <= 1'b0;
    end else begin
      tx_cfg_ff      <= nxt_tx_cfg;
      rx_cfg_ff      <= nxt_rx_cfg;
      prdata_ff      <= nxt_prdata;
      pready_ff      <= nxt_pready;
      pslverr_ff     <= nxt_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each direction reads only its own register.
  always_comb begin
    tx_if.sel     = scrmr_sel_e'(tx_cfg_ff[CFG_SEL_LSB +: 3]);
    tx_if.pc_en   = tx_cfg_ff[CFG_PC_BIT];
    tx_if.pc_inst = tx_cfg_ff[CFG_PC_INST];
    tx_if.fm_en   = tx_cfg_ff[CFG_FM_BIT];
    tx_if.fm_inst = tx_cfg_ff[CFG_FM_INST];
    tx_if.rs_en   = tx_cfg_ff[CFG_RS_BIT];
    rx_if.sel     = scrmr_sel_e'(rx_cfg_ff[CFG_SEL_LSB +: 3]);
    rx_if.pc_en   = rx_cfg_ff[CFG_PC_BIT];
    rx_if.pc_inst = rx_cfg_ff[CFG_PC_INST];
    rx_if.fm_en   = rx_cfg_ff[CFG_FM_BIT];
    rx_if.fm_inst = rx_cfg_ff[CFG_FM_INST];
    rx_if.rs_en   = rx_cfg_ff[CFG_RS_BIT];
  end

  scrmr_dir_resolver u_tx (
    .MCLK (MCLK),
    .RST  (RST),
    .dir  (tx_if.res)
  );

  scrmr_dir_resolver u_rx (
    .MCLK (MCLK),
    .RST  (RST),
    .dir  (rx_if.res)
  );

  assign TX_SCRAMBLER   = tx_if.use_sel;
  assign TX_INVERT      = tx_if.invert;
  assign RX_DESCRAMBLER = rx_if.use_sel;
  assign RX_INVERT      = rx_if.invert;
  assign PRDATA         = prdata_ff;
  assign PREADY         = pready_ff;
  assign PSLVERR        = pslverr_ff;

endmodule : scrmr_top

/* File: tb/scrmr_top_checker.sv */
module scrmr_top_checker
  import scrmr_pkg::*;
(
  // Clock and reset.
  input wire logic        MCLK,
  input wire logic        RST,
  // APB.
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic        PREADY,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  // Transmit result.
  input scrmr_use_e       TX_SCRAMBLER,
  input wire logic        TX_INVERT
);
  import scrmr_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // A result trails its write by two edges: one for the register, one for the resolver.
  wire        acc = PSEL && PENABLE && PREADY && PWRITE;
  wire        wt  = acc && PADDR == ADDR_TX_CFG;
  wire [2:0]  m   = PWDATA[CFG_SEL_LSB +: 3];
  wire        pc  = PWDATA[CFG_PC_BIT] & PWDATA[CFG_PC_INST];
  wire        fm  = PWDATA[CFG_FM_BIT] & PWDATA[CFG_FM_INST];
  scrmr_use_e f1;
  assign f1 = fm ? USE_FRAMING_SYNC : PWDATA[CFG_RS_BIT] ? USE_RS_SYNC : USE_SAT_SELFSYNC;
  AST_AUTO_STD: assert property (wt && m == 3'h0 && !pc |-> ##2 TX_SCRAMBLER == $past(f1, 2))
    else $error("auto without product code wrong");
  AST_AUTO_PC: assert property (wt && m == 3'h0 && pc && !fm |-> ##2 TX_SCRAMBLER == USE_PC_SYNC)
    else $error("auto product code wrong");
  AST_AUTO_BOTH: assert property (wt && m == 3'h0 && pc && fm |-> ##2 TX_SCRAMBLER == USE_FRAMING_SYNC)
    else $error("auto with multiplexer wrong");
  AST_FIRST: assert property (wt && m == 3'h1 |-> ##2 TX_SCRAMBLER == $past(f1, 2) && !TX_INVERT)
    else $error("first standard wrong");
  AST_SECOND: assert property (wt && m == 3'h2 |-> ##2 TX_SCRAMBLER ==
    ($past(fm, 2) ? USE_FRAMING_SYNC : USE_SAT_SELFSYNC)) else $error("second standard wrong");
  AST_FIXED: assert property (wt && (m == 3'h3 || m == 3'h4) |-> ##2 !TX_INVERT && TX_SCRAMBLER ==
    ($past(m, 2) == 3'h3 ? USE_V35_SELFSYNC : USE_SAT_SELFSYNC)) else $error("fixed mode wrong");
  AST_ALT: assert property (wt && (m == 3'h5 || m == 3'h6) |-> ##2 TX_INVERT && TX_SCRAMBLER ==
    ($past(m, 2) == 3'h5 ? USE_V35_SELFSYNC : USE_SAT_SELFSYNC)) else $error("alternate mode wrong");
  AST_SPLIT: assert property (acc && PADDR == ADDR_RX_CFG |-> ##2 $stable(TX_SCRAMBLER) && $stable(TX_INVERT))
    else $error("receive write moved transmit");
  CVR_AUTO_PC: cover property (wt && m == 3'h0 && pc && !fm);
  CVR_ALT: cover property (wt && m == 3'h5);
  CVR_RX: cover property (acc && PADDR == ADDR_RX_CFG);
endmodule // scrmr_top_checker

bind scrmr_top scrmr_top_checker u_scrmr_top_checker (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PREADY(PREADY), .PADDR(PADDR), .PWDATA(PWDATA), .TX_SCRAMBLER(TX_SCRAMBLER),
  .TX_INVERT(TX_INVERT));

/* File: tb/scrmr_dp_model.sv */
module scrmr_dp_model
  import scrmr_pkg::*;
(
  // Clock.
  input wire logic  mclk,
  // Resolved setting and data.
  input scrmr_use_e use_sel,
  input wire logic  invert,
  input wire logic  din,
  output logic      dout
);
  import scrmr_pkg::*;
  // Only the inversion is modelled; scrambling itself is the data path's business.
  always_ff @(posedge mclk) begin
    dout <= din ^ invert;
  end
endmodule // scrmr_dp_model

/* File: tb/scrambler_mode_resolver_test.sv */
module scrambler_mode_resolver_test;
  timeunit 1ns;
  timeprecision 1ns;
  import scrmr_pkg::*;
  logic        mclk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, din = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, tc, rc;
  logic [3:0]  e, f;
  logic        pready, pslverr, txi, rxi, err, dout;
  scrmr_use_e  txs, rxs;
  int          n_fail = 0, n_checks = 0;
  always #10 mclk = ~mclk;
  scrmr_top u_scrmr_top (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_SCRAMBLER(txs), .TX_INVERT(txi),
    .RX_DESCRAMBLER(rxs), .RX_INVERT(rxi));
  scrmr_dp_model u_scrmr_dp_model (.mclk(mclk), .use_sel(txs), .invert(txi), .din(din), .dout(dout));
  task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
    n_checks++;
    if (s !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  // Reference resolution: auto picks a standard or the product-code scrambler, then the mode decides.
  function automatic logic [3:0] mdl(logic [31:0] c);
    logic       pc, fm;
    logic [2:0] m, u;
    pc = c[CFG_PC_BIT] & c[CFG_PC_INST];
    fm = c[CFG_FM_BIT] & c[CFG_FM_INST];
    m = c[CFG_SEL_LSB +: 3];
    if (m == 3'h0) m = (pc && !fm) ? 3'h7 : 3'h1;
    case (m)
      3'h1: u = fm ? 3'h2 : c[CFG_RS_BIT] ? 3'h3 : 3'h0;
      3'h2: u = fm ? 3'h2 : 3'h0;
      3'h3, 3'h5: u = 3'h1;
      3'h7: u = 3'h4;
      default: u = 3'h0;
    endcase
    return {m == 3'h5 || m == 3'h6, u};
  endfunction
  task automatic summarize();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(99624));
    repeat (10) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    chk("reset", 32'h0, {txi, txs, rxi, rxs});
    $display("Test reset done");
    for (int i = 0; i < 256; i++) begin
      tc = {22'h0, i[7:6], 1'b0, i[5:3], 1'b0, i[2:0]} | ($urandom & 32'hFFFF_FC88);
      rc = $urandom;
      din <= 1'($urandom);
      e = mdl(tc);
      f = mdl(rc);
      apb(1, ADDR_TX_CFG, tc);
      apb(1, ADDR_RX_CFG, rc);
      repeat (3) @(posedge mclk);
      chk("tx", e, {txi, txs});
      chk("rx", f, {rxi, rxs});
      chk("data", din ^ e[3], dout);
      apb(0, ADDR_STATUS, 32'h0);
      chk("status", {19'h0, f[3], 1'b0, f[2:0], 3'h0, e[3], 1'b0, e[2:0]}, rd);
      chk("okerr", 32'h0, err);
      apb(0, ADDR_TX_CFG, 32'h0);
      chk("txcfg", tc & 32'h0000_0377, rd);
    end
    $display("Test modes done");
    apb(1, 8'h0C, 32'hFFFF_FFFF);
    chk("slverr", 32'h1, err);
    apb(0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("rdslverr", 32'h1, err);
    apb(0, ADDR_TX_CFG, 32'h0);
    chk("kept", tc & 32'h0000_0377, rd);
    $display("Test unmapped done");
    summarize();
  end
endmodule // scrambler_mode_resolver_test
